/* design/ijcmr_cfg.svh */
`ifndef IJCMR_CFG_SVH
`define IJCMR_CFG_SVH

// Register numbers as the master addresses them
`define IJCMR_ADDR_W 20
`define IJCMR_ADDR_FLOW_LO 20'h61eec
`define IJCMR_ADDR_FLOW_HI 20'h61eee
`define IJCMR_ADDR_AIN_CTRL 20'h61ef0
`define IJCMR_ADDR_CUR_LO 20'h61ef2
`define IJCMR_ADDR_CUR_HI 20'h61ef4
`define IJCMR_ADDR_TOT_CLR 20'h61ef6
`define IJCMR_ADDR_ALM_CLR 20'h61ef8
`define IJCMR_ADDR_BAT_HI 20'h61efa
`define IJCMR_ADDR_BAT_LO 20'h61efb
`define IJCMR_ADDR_ALM_HI 20'h61efc
`define IJCMR_ADDR_ALM_LO 20'h61efd
`define IJCMR_ADDR_TANK_HI 20'h61efe
`define IJCMR_ADDR_TANK_LO 20'h61eff
`define IJCMR_ADDR_KF_HI 20'h61f00
`define IJCMR_ADDR_KF_LO 20'h61f01

// Current setpoint limits, 0.01 mA steps
`define IJCMR_CUR_MIN 32'h0000_0190
`define IJCMR_CUR_MAX 32'h0000_07d0
`define IJCMR_CUR_STEP 16'h0001
`define IJCMR_CUR_GAP 16'h0002

// Flow-rate setpoint limits, 0.01 gallon steps
`define IJCMR_FLOW_MIN 32'h0000_000a
`define IJCMR_FLOW_MAX 32'h0000_ea60

// Command value that fires a clear
`define IJCMR_CMD_FIRE 32'h0000_0001
`define IJCMR_CMD_IDLE 32'h0000_0000

// Mode field code that selects flow control
`define IJCMR_AIN_FLOW_CODE 32'h0000_0001

// Alarm word: keeps the defined bits, forces bits 0, 11 and 15 low
`define IJCMR_ALM_UNUSED_MASK 16'h77fe

`endif

/* design/ijcmr_pkg.sv */
package ijcmr_pkg;

  // Analog input control field
  typedef enum logic [0:0] {
    AIN_OFF,
    AIN_FLOW
  } ijcmr_ain_mode_e;

  // Stored setpoint word
  typedef logic [15:0] ijcmr_word_t;

endpackage

/* design/ijcmr_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ijcmr_cfg.svh"

module ijcmr_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`IJCMR_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Live status from the controller
  input wire logic [15:0] battery_mv,
  input wire logic [15:0] alarm_active,
  input wire logic [15:0] alarm_relay_mode,
  input wire logic [15:0] tank_height,
  input wire logic tank_level_monitor,
  input wire logic [15:0] meter_scale,
  // Setpoints and mode toward the controller
  output logic [15:0] flow_low_setpoint,
  output logic [15:0] flow_high_setpoint,
  output logic flow_setpoints_apply,
  output logic [15:0] current_low_setpoint,
  output logic [15:0] current_high_setpoint,
  // One-cycle commands
  output logic volume_total_clear_pulse,
  output logic alarm_clear_pulse
);

  // Stored state
  ijcmr_pkg::ijcmr_word_t flow_lo_q, flow_lo_d;
  ijcmr_pkg::ijcmr_word_t flow_hi_q, flow_hi_d;
  ijcmr_pkg::ijcmr_word_t cur_lo_q, cur_lo_d;
  ijcmr_pkg::ijcmr_word_t cur_hi_q, cur_hi_d;
  ijcmr_pkg::ijcmr_ain_mode_e ain_mode_q, ain_mode_d;
  logic [31:0] tot_last_q;
  logic [31:0] alm_last_q;
  logic tot_pulse_q;
  logic alm_pulse_q;
  logic apply_q;
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q;

  // Address decode
  wire logic hit_flow_lo = reg_addr == `IJCMR_ADDR_FLOW_LO;
  wire logic hit_flow_hi = reg_addr == `IJCMR_ADDR_FLOW_HI;
  wire logic hit_ain = reg_addr == `IJCMR_ADDR_AIN_CTRL;
  wire logic hit_cur_lo = reg_addr == `IJCMR_ADDR_CUR_LO;
  wire logic hit_cur_hi = reg_addr == `IJCMR_ADDR_CUR_HI;
  wire logic hit_tot = reg_addr == `IJCMR_ADDR_TOT_CLR;
  wire logic hit_alm = reg_addr == `IJCMR_ADDR_ALM_CLR;

  // Write strobes, one per writable register
  wire logic wr_flow_lo = reg_wr && hit_flow_lo;
  wire logic wr_flow_hi = reg_wr && hit_flow_hi;
  wire logic wr_ain = reg_wr && hit_ain;
  wire logic wr_cur_lo = reg_wr && hit_cur_lo;
  wire logic wr_cur_hi = reg_wr && hit_cur_hi;
  wire logic wr_tot = reg_wr && hit_tot;
  wire logic wr_alm = reg_wr && hit_alm;

  // Stored values widened for comparison with the 32-bit write data
  wire logic [31:0] cur_lo_w = {16'h0000, cur_lo_q};
  wire logic [31:0] cur_hi_w = {16'h0000, cur_hi_q};

  // Low current setpoint: range 400..2000 and strictly below the high one
  wire logic [15:0] cur_lo_ceil = cur_hi_q - `IJCMR_CUR_STEP;
  wire logic cur_lo_under = reg_wdata < `IJCMR_CUR_MIN;
  wire logic cur_lo_over = (reg_wdata > `IJCMR_CUR_MAX) || (reg_wdata >= cur_hi_w);
  wire logic [15:0] cur_lo_clamped = cur_lo_under ? 16'(`IJCMR_CUR_MIN) :
                                     cur_lo_over ? cur_lo_ceil : reg_wdata[15:0];

  // High current setpoint: must exceed low plus one step, at most 2000
  wire logic [31:0] cur_hi_floor_w = cur_lo_w + {16'h0000, `IJCMR_CUR_GAP};
  wire logic [15:0] cur_hi_floor = (cur_hi_floor_w > `IJCMR_CUR_MAX) ?
                                   16'(`IJCMR_CUR_MAX) : cur_hi_floor_w[15:0];
  wire logic cur_hi_under = reg_wdata < cur_hi_floor_w;
  wire logic cur_hi_over = reg_wdata > `IJCMR_CUR_MAX;
  wire logic [15:0] cur_hi_clamped = cur_hi_over ? 16'(`IJCMR_CUR_MAX) :
                                     cur_hi_under ? cur_hi_floor : reg_wdata[15:0];

  // Flow-rate setpoints held within 10..60000
  wire logic [15:0] flow_clamped = (reg_wdata < `IJCMR_FLOW_MIN) ? 16'(`IJCMR_FLOW_MIN) :
                                   (reg_wdata > `IJCMR_FLOW_MAX) ? 16'(`IJCMR_FLOW_MAX) :
                                   reg_wdata[15:0];

  // Mode field: only the two coded values are taken, anything else means off
  wire logic ain_flow_wr = reg_wdata == `IJCMR_AIN_FLOW_CODE;

  // Commands fire only on a change to the firing value
  wire logic tot_fire = wr_tot && (reg_wdata == `IJCMR_CMD_FIRE) &&
                        (tot_last_q != `IJCMR_CMD_FIRE);
  wire logic alm_fire = wr_alm && (reg_wdata == `IJCMR_CMD_FIRE) &&
                        (alm_last_q != `IJCMR_CMD_FIRE);

  // Alarm word: active and not in relay mode, unused bits held low
  wire logic [15:0] alarm_word = alarm_active & ~alarm_relay_mode &
                                 `IJCMR_ALM_UNUSED_MASK;

  // Tank height only on units with level monitoring
  wire logic [15:0] tank_word = tank_level_monitor ? tank_height : 16'h0000;

  // Next values of the setpoints; read-only addresses never reach these
  always_comb begin
    flow_lo_d = wr_flow_lo ? flow_clamped : flow_lo_q;
    flow_hi_d = wr_flow_hi ? flow_clamped : flow_hi_q;
    cur_lo_d = wr_cur_lo ? cur_lo_clamped : cur_lo_q;
    cur_hi_d = wr_cur_hi ? cur_hi_clamped : cur_hi_q;
    ain_mode_d = ain_mode_q;
    if (wr_ain) begin
      ain_mode_d = ain_flow_wr ? ijcmr_pkg::AIN_FLOW : ijcmr_pkg::AIN_OFF;
    end
  end

  // Read mux; write-only, unused upper and unmapped words read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (reg_addr)
      `IJCMR_ADDR_FLOW_LO: rdata_d = {16'h0000, flow_lo_q};
      `IJCMR_ADDR_FLOW_HI: rdata_d = {16'h0000, flow_hi_q};
      `IJCMR_ADDR_AIN_CTRL: rdata_d = {31'h0000_0000, ain_mode_q == ijcmr_pkg::AIN_FLOW};
      `IJCMR_ADDR_CUR_LO: rdata_d = cur_lo_w;
      `IJCMR_ADDR_CUR_HI: rdata_d = cur_hi_w;
      `IJCMR_ADDR_BAT_LO: rdata_d = {16'h0000, battery_mv};
      `IJCMR_ADDR_ALM_LO: rdata_d = {16'h0000, alarm_word};
      `IJCMR_ADDR_TANK_LO: rdata_d = {16'h0000, tank_word};
      `IJCMR_ADDR_KF_LO: rdata_d = {16'h0000, meter_scale};
      `IJCMR_ADDR_BAT_HI, `IJCMR_ADDR_ALM_HI,
      `IJCMR_ADDR_TANK_HI, `IJCMR_ADDR_KF_HI: rdata_d = 32'h0000_0000;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Setpoint and mode registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      flow_lo_q <= 16'(`IJCMR_FLOW_MIN);
      flow_hi_q <= 16'(`IJCMR_FLOW_MAX);
      cur_lo_q <= 16'(`IJCMR_CUR_MIN);
      cur_hi_q <= 16'(`IJCMR_CUR_MAX);
      ain_mode_q <= ijcmr_pkg::AIN_OFF;
    end else begin
      flow_lo_q <= flow_lo_d;
      flow_hi_q <= flow_hi_d;
      cur_lo_q <= cur_lo_d;
      cur_hi_q <= cur_hi_d;
      ain_mode_q <= ain_mode_d;
    end
  end

  // Last written command values and the resulting pulses
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tot_last_q <= `IJCMR_CMD_IDLE;
      alm_last_q <= `IJCMR_CMD_IDLE;
      tot_pulse_q <= 1'b0;
      alm_pulse_q <= 1'b0;
    end else begin
      if (wr_tot) begin
        tot_last_q <= reg_wdata;
      end
      if (wr_alm) begin
        alm_last_q <= reg_wdata;
      end
      tot_pulse_q <= tot_fire;
      alm_pulse_q <= alm_fire;
    end
  end

  // Flow setpoints are handed on only while analog input is in flow mode
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      apply_q <= 1'b0;
    end else begin
      apply_q <= ain_mode_d == ijcmr_pkg::AIN_FLOW;
    end
  end

  // Registered read answer, one cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
      rvalid_q <= reg_rd;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign flow_low_setpoint = flow_lo_q;
  assign flow_high_setpoint = flow_hi_q;
  assign flow_setpoints_apply = apply_q;
  assign current_low_setpoint = cur_lo_q;
  assign current_high_setpoint = cur_hi_q;
  assign volume_total_clear_pulse = tot_pulse_q;
  assign alarm_clear_pulse = alm_pulse_q;

endmodule // ijcmr_regs
`default_nettype wire

/* dv/ijcmr_master.sv */
`timescale 1ns/100ps
`default_nettype none

module ijcmr_master (
  // Clock
  input wire logic ref_clk,
  // Register access toward the bank
  output logic reg_wr, reg_rd,
  output logic [19:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle bus from time zero
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // Write held for its taking edge, data scrambled once released
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk) {reg_wr, reg_wdata} <= {1'b0, ~d};
  endtask
  // Read answer taken one edge after the taking edge
  task automatic rd(input logic [19:0] a, output logic [31:0] d);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_rd <= 1'b0;
    @(posedge ref_clk) d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
  endtask
endmodule // ijcmr_master
`default_nettype wire

/* dv/ijcmr_regs_props.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ijcmr_cfg.svh"

module ijcmr_regs_props (
  // Clock, reset and access strobes
  input wire logic ref_clk, reset_n, reg_wr, reg_rd, reg_rvalid,
  input wire logic [19:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata,
  // Live status and outputs toward the controller
  input wire logic [15:0] battery_mv, alarm_active, alarm_relay_mode, tank_height,
  input wire logic tank_level_monitor, flow_setpoints_apply,
  input wire logic [15:0] current_low_setpoint, current_high_setpoint,
  input wire logic volume_total_clear_pulse, alarm_clear_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Current setpoints stay ordered and inside their span
  a_cur_order: assert property (current_low_setpoint < current_high_setpoint)
    else $error("current setpoints out of order");
  a_cur_span: assert property (current_low_setpoint >= 16'h0190 &&
    current_high_setpoint <= 16'h07d0) else $error("current setpoint out of span");
  // Status reads answer one cycle on with the live value
  a_bat_read: assert property (reg_rd && reg_addr == `IJCMR_ADDR_BAT_LO |=>
    reg_rvalid && reg_rdata == {16'h0, $past(battery_mv)}) else $error("battery read wrong");
  a_alarm_read: assert property (reg_rd && reg_addr == `IJCMR_ADDR_ALM_LO |=>
    reg_rdata == {16'h0, $past(alarm_active) & ~$past(alarm_relay_mode) & 16'h77fe})
    else $error("alarm word wrong");
  a_tank_read: assert property (reg_rd && reg_addr == `IJCMR_ADDR_TANK_LO &&
    tank_level_monitor |=> reg_rdata == {16'h0, $past(tank_height)}) else $error("tank read");
  a_upper_zero: assert property (reg_rd && !reg_addr[0] && reg_addr >= `IJCMR_ADDR_BAT_HI &&
    reg_addr <= `IJCMR_ADDR_KF_HI |=> reg_rdata == 32'h0) else $error("upper word not zero");
  // Command pulses come only from a write of one, and last one cycle
  a_tot_pulse: assert property (volume_total_clear_pulse |-> $past(reg_wr) &&
    $past(reg_addr) == `IJCMR_ADDR_TOT_CLR && $past(reg_wdata) == 32'h1
    ##1 !volume_total_clear_pulse) else $error("total clear pulse wrong");
  a_alm_pulse: assert property (alarm_clear_pulse |-> $past(reg_wr) &&
    $past(reg_addr) == `IJCMR_ADDR_ALM_CLR && $past(reg_wdata) == 32'h1
    ##1 !alarm_clear_pulse) else $error("alarm clear pulse wrong");
  a_mode_apply: assert property (reg_wr && reg_addr == `IJCMR_ADDR_AIN_CTRL |=>
    flow_setpoints_apply == ($past(reg_wdata) == 32'h1)) else $error("mode not applied");
  // Main scenarios reached
  c_tot: cover property (volume_total_clear_pulse);
  c_alm: cover property (alarm_clear_pulse);
  c_apply: cover property (flow_setpoints_apply);
endmodule // ijcmr_regs_props

bind ijcmr_regs ijcmr_regs_props u_props (.ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_rvalid,
  .reg_addr, .reg_wdata, .reg_rdata, .battery_mv, .alarm_active, .alarm_relay_mode,
  .tank_height, .tank_level_monitor, .flow_setpoints_apply, .current_low_setpoint,
  .current_high_setpoint, .volume_total_clear_pulse, .alarm_clear_pulse);
`default_nettype wire

/* dv/injection_ctrl_modbus_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ijcmr_cfg.svh"

module injection_ctrl_modbus_regs_bench;
  logic ref_clk, reset_n, reg_wr, reg_rd, reg_rvalid, tank_level_monitor;
  logic flow_setpoints_apply, volume_total_clear_pulse, alarm_clear_pulse;
  logic [19:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] battery_mv, alarm_active, alarm_relay_mode, tank_height, meter_scale;
  logic [15:0] flow_low_setpoint, flow_high_setpoint, current_low_setpoint;
  logic [15:0] current_high_setpoint;
  int fails, checks_done, pc[2];
  // Bank under test and the master model
  ijcmr_regs u_ijcmr_regs (.ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .battery_mv, .alarm_active, .alarm_relay_mode, .tank_height,
    .tank_level_monitor, .meter_scale, .flow_low_setpoint, .flow_high_setpoint,
    .flow_setpoints_apply, .current_low_setpoint, .current_high_setpoint,
    .volume_total_clear_pulse, .alarm_clear_pulse);
  ijcmr_master mst (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
  // Comparison, read-check and write-readback helpers
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdc(input logic [19:0] a, input logic [31:0] e);
    logic [31:0] d;
    mst.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task automatic wc(input logic [19:0] a, input logic [31:0] d, e);
    mst.wr(a, d);
    rdc(a, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Clock, hang guard and command pulse counters
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #50us;
    fails++;
    wrap_up();
  end
  always @(posedge ref_clk) begin
    pc[0] += int'(volume_total_clear_pulse === 1'b1);
    pc[1] += int'(alarm_clear_pulse === 1'b1);
  end
  // Main sequence
  initial begin
    logic [19:0] a;
    reset_n = 1'b0;
    {battery_mv, alarm_active, alarm_relay_mode} = {16'hc350, 16'hffff, 16'h00f0};
    {tank_height, tank_level_monitor, meter_scale} = {16'h3840, 1'b1, 16'h270f};
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdc(`IJCMR_ADDR_FLOW_LO, 32'ha);
    wc(`IJCMR_ADDR_CUR_LO, 32'h64, 32'h190);
    wc(`IJCMR_ADDR_CUR_LO, 32'h9c4, 32'h7cf);
    wc(`IJCMR_ADDR_CUR_HI, 32'hbb8, 32'h7d0);
    wc(`IJCMR_ADDR_CUR_LO, 32'h3e8, 32'h3e8);
    wc(`IJCMR_ADDR_CUR_HI, 32'h1f4, 32'h3ea);
    chk("cur ports", {current_high_setpoint, current_low_setpoint}, 32'h03ea_03e8);
    wc(`IJCMR_ADDR_FLOW_LO, 32'h5, 32'ha);
    wc(`IJCMR_ADDR_FLOW_HI, 32'h11170, 32'hea60);
    chk("flow ports", {flow_high_setpoint, flow_low_setpoint}, 32'hea60_000a);
    wc(`IJCMR_ADDR_AIN_CTRL, 32'h1, 32'h1);
    chk("apply on", flow_setpoints_apply, 32'h1);
    wc(`IJCMR_ADDR_AIN_CTRL, 32'h2, 32'h0);
    chk("apply off", flow_setpoints_apply, 32'h0);
    // Clear commands fire only when one follows another value
    foreach (pc[i]) begin
      a = i ? `IJCMR_ADDR_ALM_CLR : `IJCMR_ADDR_TOT_CLR;
      mst.wr(a, 32'h1);
      mst.wr(a, 32'h1);
      mst.wr(a, 32'h0);
      wc(a, 32'h1, 32'h0);
      chk("clear pulses", pc[i], 32'h2);
    end
    // Status words, read-only and unmapped places
    rdc(`IJCMR_ADDR_BAT_LO, 32'hc350);
    rdc(`IJCMR_ADDR_ALM_LO, 32'h770e);
    rdc(`IJCMR_ADDR_TANK_LO, 32'h3840);
    rdc(`IJCMR_ADDR_KF_LO, 32'h270f);
    for (int i = 0; i < 4; i++)
      wc(20'h61efa + 20'(2 * i), 32'hffff, 32'h0);
    wc(`IJCMR_ADDR_BAT_LO, 32'h1234, 32'hc350);
    wc(20'h61f02, 32'hffff_ffff, 32'h0);
    @(posedge ref_clk) tank_level_monitor <= 1'b0;
    rdc(`IJCMR_ADDR_TANK_LO, 32'h0);
    // Walk one alarm bit at a time across the word
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk) {alarm_active, alarm_relay_mode} <= {16'h1 << i, 16'h0};
      rdc(`IJCMR_ADDR_ALM_LO, 32'h77fe & (32'h1 << i));
    end
    @(posedge ref_clk) {alarm_active, alarm_relay_mode} <= {16'hffff, 16'hffff};
    rdc(`IJCMR_ADDR_ALM_LO, 32'h0);
    wrap_up();
  end
endmodule // injection_ctrl_modbus_regs_bench
`default_nettype wire
